// ===== rtl/pat_pkg.sv
// Constants shared by the paged address translation block.
package pat_pkg;
  // Table entry fields.
  localparam int ENT_PRESENT = 0;
  localparam int ENT_WRITE = 1;
  localparam int ENT_USER = 2;
  localparam int ENT_WT = 3;
  localparam int ENT_CD = 4;
  localparam int ENT_LARGE = 7;
  // Virtual address fields and frame widths.
  localparam int VA_DIR_LSB = 22;
  localparam int VA_PAGE_LSB = 12;
  localparam int IDX_W = 10;
  localparam int FRAME_SMALL_W = 20;
  localparam int FRAME_LARGE_W = 10;
  localparam int OFS_SMALL_W = 12;
  localparam int OFS_LARGE_W = 22;
  localparam logic [1:0] ENTRY_BYTE_OFS = 2'h0;
  // Directory base register: base field and translation enable bit.
  localparam int DIRBASE_EN_BIT = 5;
  localparam int DTB_LSB = 12;
  localparam logic [31:0] DIRBASE_RESET = 32'h0000_0000;
  // Status registers: user bit, previous user bit, write protect, page mode.
  localparam int PSR_U_BIT = 1;
  localparam int PSR_PU_BIT = 2;
  localparam int EPSR_WP_BIT = 5;
  localparam int EPSR_PBM_BIT = 6;
  // Control register selectors for control register stores.
  localparam logic [1:0] CTL_DIRBASE = 2'h0;
  localparam logic [1:0] CTL_PSR = 2'h1;
  localparam logic [1:0] CTL_EPSR = 2'h2;
  // Walk states, Gray coded along idle -> directory -> table.
  typedef enum logic [1:0] {
    PAT_IDLE = 2'h0,
    PAT_DIR = 2'h1,
    PAT_TBL = 2'h3
  } pat_state_t;
endpackage

// ===== rtl/pat_check.sv
// Page-level protection check for one table entry.
`timescale 1ns/1ps
module pat_check (
  input wire logic [31:0] entry_i,
  input wire logic user_i,
  input wire logic write_i,
  input wire logic wp_i,
  output logic absent_o,
  output logic fault_o
);
  import pat_pkg::*;

  // A not-present entry masks every other bit of the entry.
  always_comb begin
    absent_o = ~entry_i[ENT_PRESENT];
    fault_o = absent_o;
    if (!absent_o) begin
      // User level cannot reach supervisor pages at all.
      if (user_i && !entry_i[ENT_USER]) begin
        fault_o = 1'b1;
      end
      // Writes to read-only pages trap at user level, or under write protect.
      if (write_i && !entry_i[ENT_WRITE] && (user_i || wp_i)) begin
        fault_o = 1'b1;
      end
    end
  end
endmodule

// ===== rtl/pat_top.sv
// Paged virtual-to-physical address translation with page protection.
`timescale 1ns/1ps
module pat_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic large_variant_i,
  input wire logic ctl_store_i,
  input wire logic [1:0] ctl_store_sel_i,
  input wire logic [31:0] ctl_store_data_i,
  input wire logic trap_i,
  input wire logic ind_branch_i,
  input wire logic trap_bits_set_i,
  input wire logic priv_op_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_vaddr_i,
  input wire logic req_write_i,
  input wire logic req_instr_i,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  output logic req_ready_o,
  output logic mem_req_o,
  output logic [31:0] mem_addr_o,
  output logic rsp_valid_o,
  output logic [31:0] rsp_paddr_o,
  output logic rsp_bus_go_o,
  output logic rsp_data_fault_o,
  output logic rsp_instr_fault_o,
  output logic rsp_write_through_o,
  output logic rsp_dcache_inhibit_o,
  output logic rsp_icache_inhibit_o,
  output logic page_attribute_output_pin_o,
  output logic priv_op_done_o,
  output logic translation_enable_o,
  output logic user_mode_o,
  output logic previous_privilege_bit_o,
  output logic write_protect_o
);
  import pat_pkg::*;

  // Entry address: frame base, ten-bit index, word aligned.
  function automatic logic [31:0] entry_addr(input logic [19:0] base,
                                             input logic [9:0] idx);
    entry_addr = {base, idx, ENTRY_BYTE_OFS};
  endfunction

  logic rst_meta;
  logic rst_sync;
  logic large_mode;
  logic strap_taken;
  logic [31:0] dirbase;
  logic user;
  logic prev_user;
  logic wp;
  logic page_bit_mode_select;
  pat_state_t state;
  pat_state_t next_state;
  logic [31:0] vaddr;
  logic write_q;
  logic instr_q;
  logic [31:0] dir_entry;
  logic chk_absent;
  logic chk_fault;
  logic done;
  logic done_fault;
  logic [31:0] done_paddr;
  logic done_wt;
  logic done_cd;
  logic start;
  logic big_page;

  // Reset is released through two flops so every flop leaves reset together.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // The variant strap is caught once, on the first edge after release.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      large_mode <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      large_mode <= large_variant_i;
      strap_taken <= 1'b1;
    end
  end

  // Directory base register; user-level stores to it are dropped.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      dirbase <= DIRBASE_RESET;
    end else if (ctl_store_i && ctl_store_sel_i == CTL_DIRBASE && !user) begin
      dirbase <= ctl_store_data_i;
    end
  end

  // Extended status: write protect and page attribute mode.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      wp <= 1'b0;
      page_bit_mode_select <= 1'b0;
    end else if (ctl_store_i && ctl_store_sel_i == CTL_EPSR && !user) begin
      wp <= ctl_store_data_i[EPSR_WP_BIT];
      page_bit_mode_select <= ctl_store_data_i[EPSR_PBM_BIT];
    end
  end

  // Privilege state. A trap outranks a return in the same cycle, and a
  // user-level status store cannot raise or alter the privilege bits.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      user <= 1'b0;
      prev_user <= 1'b0;
    end else if (trap_i) begin
      prev_user <= user;
      user <= 1'b0;
    end else if (ind_branch_i && trap_bits_set_i) begin
      user <= prev_user;
    end else if (ctl_store_i && ctl_store_sel_i == CTL_PSR && !user) begin
      user <= ctl_store_data_i[PSR_U_BIT];
      prev_user <= ctl_store_data_i[PSR_PU_BIT];
    end
  end

  // Privileged I/O, cycle and interrupt-load operations act only at
  // supervisor level.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      priv_op_done_o <= 1'b0;
    end else begin
      priv_op_done_o <= priv_op_i && !user;
    end
  end

  // Status copies for the core.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      translation_enable_o <= 1'b0;
      user_mode_o <= 1'b0;
      previous_privilege_bit_o <= 1'b0;
      write_protect_o <= 1'b0;
    end else begin
      translation_enable_o <= dirbase[DIRBASE_EN_BIT];
      user_mode_o <= user;
      previous_privilege_bit_o <= prev_user;
      write_protect_o <= wp;
    end
  end

  assign start = req_valid_i && state == PAT_IDLE;

  // One checker serves both levels; checking each level on its own gives
  // the more restrictive of the two for a 4-Kbyte page.
  pat_check u_check (
    .entry_i(mem_rdata_i),
    .user_i(user),
    .write_i(write_q),
    .wp_i(wp),
    .absent_o(chk_absent),
    .fault_o(chk_fault)
  );

  // Only the larger variant honours the page-size bit of a directory entry;
  // the smaller one always walks to a second-level table.
  assign big_page = large_mode && mem_rdata_i[ENT_LARGE];

  // Walk sequencing and the completion of each access.
  always_comb begin
    next_state = state;
    done = 1'b0;
    done_fault = 1'b0;
    done_paddr = vaddr;
    done_wt = 1'b0;
    done_cd = 1'b0;
    case (state)
      PAT_IDLE: begin
        if (start && !dirbase[DIRBASE_EN_BIT]) begin
          done = 1'b1;
          done_paddr = req_vaddr_i;
        end else if (start) begin
          next_state = PAT_DIR;
        end
      end
      PAT_DIR: begin
        if (mem_ack_i) begin
          if (chk_fault) begin
            done = 1'b1;
            done_fault = 1'b1;
            next_state = PAT_IDLE;
          end else if (big_page) begin
            done = 1'b1;
            done_paddr = {mem_rdata_i[31 -: FRAME_LARGE_W],
                          vaddr[OFS_LARGE_W-1:0]};
            done_wt = mem_rdata_i[ENT_WT];
            done_cd = mem_rdata_i[ENT_CD];
            next_state = PAT_IDLE;
          end else begin
            next_state = PAT_TBL;
          end
        end
      end
      PAT_TBL: begin
        if (mem_ack_i) begin
          done = 1'b1;
          done_fault = chk_fault;
          done_paddr = {mem_rdata_i[31 -: FRAME_SMALL_W],
                        vaddr[OFS_SMALL_W-1:0]};
          done_wt = mem_rdata_i[ENT_WT];
          done_cd = mem_rdata_i[ENT_CD];
          next_state = PAT_IDLE;
        end
      end
      default: begin
        next_state = PAT_IDLE;
      end
    endcase
  end

  // State and the captured request.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= PAT_IDLE;
      vaddr <= 32'h0000_0000;
      write_q <= 1'b0;
      instr_q <= 1'b0;
      dir_entry <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (start) begin
        vaddr <= req_vaddr_i;
        write_q <= req_write_i;
        instr_q <= req_instr_i;
      end
      if (state == PAT_DIR && mem_ack_i) begin
        dir_entry <= mem_rdata_i;
      end
    end
  end

  // Table reads. The directory is indexed from its base field; the second
  // level from the frame in the directory entry just returned.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= 32'h0000_0000;
    end else if (state == PAT_IDLE && next_state == PAT_DIR) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= entry_addr(dirbase[31:DTB_LSB],
                               req_vaddr_i[31:VA_DIR_LSB]);
    end else if (state == PAT_DIR && next_state == PAT_TBL) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= entry_addr(mem_rdata_i[31:DTB_LSB],
                               vaddr[VA_DIR_LSB-1:VA_PAGE_LSB]);
    end else if (mem_ack_i) begin
      mem_req_o <= 1'b0;
    end
  end

  // A new request is taken only while the walker is idle.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= next_state == PAT_IDLE;
    end
  end

  // Answer to the core. A faulting access never reaches the bus; the core
  // sees the fault class instead. On the smaller variant write-through is
  // not a real policy: a set bit keeps data out of the data cache and, with page attribute mode clear, drives the page attribute pin.
  always_ff @(posedge sys_clk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      rsp_valid_o <= 1'b0;
      rsp_paddr_o <= 32'h0000_0000;
      rsp_bus_go_o <= 1'b0;
      rsp_data_fault_o <= 1'b0;
      rsp_instr_fault_o <= 1'b0;
      rsp_write_through_o <= 1'b0;
      rsp_dcache_inhibit_o <= 1'b0;
      rsp_icache_inhibit_o <= 1'b0;
      page_attribute_output_pin_o <= 1'b0;
    end else begin
      rsp_valid_o <= done;
      rsp_bus_go_o <= done && !done_fault;
      rsp_data_fault_o <= done && done_fault && !instr_q;
      rsp_instr_fault_o <= done && done_fault && instr_q;
      if (done) begin
        rsp_paddr_o <= done_fault ? 32'h0000_0000 : done_paddr;
        rsp_write_through_o <= large_mode && done_wt;
        rsp_dcache_inhibit_o <= done_cd ||
                                (!large_mode && done_wt);
        rsp_icache_inhibit_o <= done_cd;
        page_attribute_output_pin_o <= page_bit_mode_select ? done_cd : done_wt;
      end
    end
  end
endmodule

// ===== verification/pat_sva.sv
// Concurrent checks on the ports of the translation block.
`timescale 1ns/1ps
module pat_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire logic [31:0] req_vaddr_i,
  input wire logic req_ready_o,
  input wire logic translation_enable_o,
  input wire logic rsp_valid_o,
  input wire logic [31:0] rsp_paddr_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_addr_o,
  input wire logic rsp_bus_go_o,
  input wire logic rsp_data_fault_o,
  input wire logic rsp_instr_fault_o,
  input wire logic trap_i,
  input wire logic user_mode_o,
  input wire logic previous_privilege_bit_o,
  input wire logic priv_op_i,
  input wire logic priv_op_done_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A request taken while addresses pass untranslated.
  sequence s_take_off;
    req_valid_i && req_ready_o && !translation_enable_o;
  endsequence
  // An answer that reports either kind of access fault.
  sequence s_fault_rsp;
    rsp_valid_o && (rsp_data_fault_o || rsp_instr_fault_o);
  endsequence
  a_off_pass: assert property (
    s_take_off |=> rsp_valid_o && rsp_paddr_o == $past(req_vaddr_i))
    else $error("untranslated answer wrong");
  a_off_nowalk: assert property (
    s_take_off |=> !mem_req_o) else $error("walk while disabled");
  a_fault_nobus: assert property (
    s_fault_rsp |-> !rsp_bus_go_o && rsp_paddr_o == 32'h0)
    else $error("faulting access still issued");
  a_fault_kind: assert property (
    s_fault_rsp |-> rsp_data_fault_o != rsp_instr_fault_o)
    else $error("fault kind ambiguous");
  a_entry_align: assert property (
    mem_req_o |-> mem_addr_o[1:0] == 2'h0) else $error("entry misaligned");
  a_read_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("table read dropped early");
  a_trap_super: assert property (
    trap_i |-> ##[1:2] !user_mode_o) else $error("trap left user level");
  a_trap_prev: assert property (
    trap_i && user_mode_o |-> ##[1:2] previous_privilege_bit_o)
    else $error("previous level not saved");
  a_user_priv: assert property (
    priv_op_i && user_mode_o |=> !priv_op_done_o)
    else $error("privileged op ran at user level");
  a_sup_priv: assert property (
    priv_op_i && !user_mode_o |=> priv_op_done_o)
    else $error("privileged op lost");
  a_go_valid: assert property (
    rsp_bus_go_o |-> rsp_valid_o) else $error("bus go without answer");
endmodule

bind pat_top pat_sva u_sva (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .req_valid_i(req_valid_i), .req_vaddr_i(req_vaddr_i),
  .req_ready_o(req_ready_o), .translation_enable_o(translation_enable_o),
  .rsp_valid_o(rsp_valid_o), .rsp_paddr_o(rsp_paddr_o),
  .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o),
  .rsp_bus_go_o(rsp_bus_go_o), .rsp_data_fault_o(rsp_data_fault_o),
  .rsp_instr_fault_o(rsp_instr_fault_o), .trap_i(trap_i),
  .user_mode_o(user_mode_o),
  .previous_privilege_bit_o(previous_privilege_bit_o),
  .priv_op_i(priv_op_i), .priv_op_done_o(priv_op_done_o));

// ===== verification/pat_mem_model.sv
// Memory holding the page tables that the walker reads.
`timescale 1ns/1ps
module pat_mem_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [31:0] addr_i,
  output logic ack_o,
  output logic [31:0] data_o
);
  logic [31:0] mem [logic [31:0]];
  int wait_n = 0;
  int cnt;
  // Answers after wait_n idle cycles; between answers the data lines
  // flip so that a stale entry is never mistaken for a fresh one.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt <= 0;
      data_o <= 32'h0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= 0;
      data_o <= ~data_o;
    end else if (req_i && cnt >= wait_n) begin
      ack_o <= 1'b1;
      data_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0;
    end else if (req_i) begin
      cnt <= cnt + 1;
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the paged address translation block.
`timescale 1ns/1ps
module tb_top;
  import pat_pkg::*;
  localparam logic [31:0] BASE = 32'h0010_0000;
  logic sys_clk_i = 0, rst_n_i = 0, large_variant_i = 1, ctl_store_i = 0;
  logic [1:0] ctl_store_sel_i = 2'h0;
  logic [31:0] ctl_store_data_i = 0, req_vaddr_i = 0, mem_rdata_i;
  logic trap_i = 0, ind_branch_i = 0, trap_bits_set_i = 0, priv_op_i = 0;
  logic req_valid_i = 0, req_write_i = 0, req_instr_i = 0, mem_ack_i;
  logic req_ready_o, mem_req_o, rsp_valid_o, rsp_bus_go_o;
  logic [31:0] mem_addr_o, rsp_paddr_o;
  logic rsp_data_fault_o, rsp_instr_fault_o, rsp_write_through_o;
  logic rsp_dcache_inhibit_o, rsp_icache_inhibit_o, priv_op_done_o;
  logic page_attribute_output_pin_o, translation_enable_o, user_mode_o;
  logic previous_privilege_bit_o, write_protect_o;
  int miscompares = 0, n_checks = 0, cyc = 0;
  pat_top uut (.*);
  pat_mem_model mm (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(mem_req_o),
    .addr_i(mem_addr_o), .ack_o(mem_ack_i), .data_o(mem_rdata_i));
  always #5 sys_clk_i = ~sys_clk_i;
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Control store; the status outputs settle within two more edges.
  task automatic st(input logic [1:0] sel, input logic [31:0] d);
    ctl_store_sel_i = sel;
    ctl_store_data_i = d;
    ctl_store_i = 1;
    @(posedge sys_clk_i) #1 ctl_store_i = 0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(posedge sys_clk_i) #1 s = 0;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic priv(input logic exp);
    priv_op_i = 1;
    @(posedge sys_clk_i) #1 priv_op_i = 0;
    chk(priv_op_done_o, exp);
  endtask
  // One translation; flt is {data fault, instruction fault}.
  task automatic xl(input logic [31:0] va, input logic wr, input logic ins,
                    input logic [31:0] pa, input logic [1:0] flt);
    int n;
    for (n = 0; n < 20 && req_ready_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
    req_vaddr_i = va;
    req_write_i = wr;
    req_instr_i = ins;
    req_valid_i = 1;
    @(posedge sys_clk_i) #1 req_valid_i = 0;
    for (n = 0; n < 60 && rsp_valid_o !== 1'b1; n++) @(posedge sys_clk_i) #1;
    chk(rsp_valid_o, 1);
    chk(rsp_paddr_o, pa);
    chk({rsp_data_fault_o, rsp_instr_fault_o}, flt);
    chk(rsp_bus_go_o, flt == 2'h0);
  endtask
  task automatic t_walk();
    mm.mem[BASE + 4] = 32'h0020_0007;
    mm.mem[32'h0020_000c] = 32'h1234_500f;
    mm.mem[BASE + 8] = 32'hc000_0087;
    xl(32'h1234_5678, 0, 0, 32'h1234_5678, 2'h0);
    st(CTL_DIRBASE, BASE | 32'h20);
    chk(translation_enable_o, 1);
    xl(32'h0040_3abc, 0, 0, 32'h1234_5abc, 2'h0);
    chk(rsp_write_through_o, 1);
    chk(page_attribute_output_pin_o, 1);
    mm.wait_n = 3;
    xl(32'h0081_2345, 1, 0, 32'hc001_2345, 2'h0);
    chk(rsp_write_through_o, 0);
    mm.wait_n = 0;
    st(CTL_EPSR, 32'h40);
    xl(32'h0040_3abc, 0, 1, 32'h1234_5abc, 2'h0);
    chk(page_attribute_output_pin_o, 0);
    $display("t_walk done");
  endtask
  task automatic t_fault();
    mm.mem[BASE + 12] = 32'hffff_fffe;
    xl(32'h00c0_0000, 0, 1, 32'h0, 2'h1);
    xl(32'h0040_4000, 1, 0, 32'h0, 2'h2);
    $display("t_fault done");
  endtask
  task automatic t_wp();
    mm.mem[BASE + 20] = 32'h0340_0085;
    st(CTL_EPSR, 32'h0);
    xl(32'h0140_0010, 1, 0, 32'h0340_0010, 2'h0);
    st(CTL_EPSR, 32'h20);
    chk(write_protect_o, 1);
    xl(32'h0140_0010, 1, 0, 32'h0, 2'h2);
    xl(32'h0140_0010, 0, 0, 32'h0340_0010, 2'h0);
    st(CTL_EPSR, 32'h0);
    priv(1);
    $display("t_wp done");
  endtask
  task automatic t_user();
    mm.mem[BASE + 16] = 32'h0300_0083;
    mm.mem[BASE + 24] = 32'h0020_0003;
    st(CTL_PSR, 32'h2);
    chk(user_mode_o, 1);
    xl(32'h0100_0000, 0, 0, 32'h0, 2'h2);
    xl(32'h0100_0000, 0, 1, 32'h0, 2'h1);
    xl(32'h0140_0010, 1, 0, 32'h0, 2'h2);
    xl(32'h0140_0010, 0, 0, 32'h0340_0010, 2'h0);
    xl(32'h0180_3000, 0, 0, 32'h0, 2'h2);
    st(CTL_DIRBASE, 32'h0);
    chk(translation_enable_o, 1);
    priv(0);
    $display("t_user done");
  endtask
  task automatic t_trap();
    pulse(trap_i);
    chk(user_mode_o, 0);
    chk(previous_privilege_bit_o, 1);
    trap_bits_set_i = 1;
    pulse(ind_branch_i);
    chk(user_mode_o, 1);
    trap_bits_set_i = 0;
    pulse(trap_i);
    st(CTL_DIRBASE, 32'h0);
    chk(translation_enable_o, 0);
    xl(32'h0040_3abc, 0, 0, 32'h0040_3abc, 2'h0);
    $display("t_trap done");
  endtask
  // Mid-run reset into the smaller variant: the size bit is ignored, so a
  // directory entry marked large still leads to a second-level table.
  task automatic t_small();
    mm.mem[32'hc000_0048] = 32'h5678_900b;
    rst_n_i = 0;
    large_variant_i = 0;
    repeat (8) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    chk(translation_enable_o, 0);
    repeat (3) @(posedge sys_clk_i);
    #1;
    st(CTL_DIRBASE, BASE | 32'h20);
    xl(32'h0081_2345, 0, 0, 32'h5678_9345, 2'h0);
    chk(rsp_write_through_o, 0);
    chk(rsp_dcache_inhibit_o, 1);
    chk(rsp_icache_inhibit_o, 0);
    chk(page_attribute_output_pin_o, 1);
    $display("t_small done");
  endtask
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    t_walk();
    t_fault();
    t_wp();
    t_user();
    t_trap();
    t_small();
    results();
  end
endmodule
